// *** verilog/csje_exec.v ***
// Execution unit for shifts, branches, immediates and context moves.
// Assumes a decoder presents one operation per start pulse and that
// workspace memory holds read data stable within the strobe cycle.
//
// Functional notes
// - Left arithmetic shift moves bits up and fills the low end with 0.
// - Right arithmetic shift fills vacated high bits with the old sign.
// - Right rotate moves the bit leaving the bottom into the top.
// - Right logical shift fills vacated high bits with zeros.
// - Above branches if flag 0 set and flag 2 clear; equal on flag 2.
// - Above-or-equal branches when flag 0 or flag 2 is set.
// - Below branches only when flags 0 and 2 are both clear.
// - Below-or-equal branches when flag 0 is clear or flag 2 set.
// - Less branches when flags 1 and 2 are clear; greater on flag 1.
// - Compare immediate sets flags only; add, and, or and load immediates write back.
// - Loading the pointer immediately leaves the flag word unchanged.
// - Mask load copies operand bits 12 to 15 into flag bits 12 to 15.
// - Return restores flags from 15, counter from 14, pointer from 13.
// - Execute runs the target instruction then resumes after itself.
// - Context call saves pointer, counter, flags into new regs 13-15.
`timescale 1ns/1ps
`include "csje_map.vh"

module csje_exec #(
  parameter W = 16
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire start_i,
  input wire [4:0] op_i,
  input wire [3:0] cond_i,
  input wire [3:0] reg_i,
  input wire [3:0] cnt_i,
  input wire [W-1:0] imm_i,
  input wire [W-1:0] disp_i,
  input wire [W-1:0] mem_rdata_i,
  output wire busy_o,
  output reg done_o,
  output reg mem_rd_o,
  output reg mem_wr_o,
  output reg [W-1:0] mem_addr_o,
  output reg [W-1:0] mem_wdata_o,
  output reg exec_fetch_o,
  output reg [W-1:0] exec_addr_o,
  output wire [W-1:0] flag_word_o,
  output wire [W-1:0] wp_o,
  output wire [W-1:0] pc_o
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam S_IDLE = 6'b000001;
  localparam S_RD = 6'b000010;
  localparam S_WAIT = 6'b000100;
  localparam S_WR = 6'b001000;
  localparam S_SEQ = 6'b010000;
  localparam S_DONE = 6'b100000;

  reg [5:0] st_ff;
  reg [5:0] nxt_st;
  reg [W-1:0] flag_ff;
  reg [W-1:0] nxt_flag;
  reg [W-1:0] wp_ff;
  reg [W-1:0] nxt_wp;
  reg [W-1:0] pc_ff;
  reg [W-1:0] nxt_pc;
  reg [4:0] op_ff;
  reg [3:0] cond_ff;
  reg [3:0] reg_ff;
  reg [3:0] cnt_ff;
  reg [W-1:0] imm_ff;
  reg [W-1:0] ctx_wp_ff;
  reg [W-1:0] nxt_ctx_wp;
  reg [1:0] step_ff;
  reg [1:0] nxt_step;
  reg [W-1:0] opnd_ff;
  reg [W-1:0] nxt_opnd;
  reg nxt_rd;
  reg nxt_wr;
  reg [W-1:0] nxt_addr;
  reg [W-1:0] nxt_wdata;
  reg nxt_done;
  reg nxt_xf;
  reg [W-1:0] nxt_xaddr;
  reg take;
  reg [W-1:0] res;
  reg [W:0] sum;
  reg [W-1:0] cmp;
  wire [W-1:0] sh_res;
  wire sh_c;
  wire [3:0] sh_cnt;

  assign busy_o = ~st_ff[0];
  assign flag_word_o = flag_ff;
  assign wp_o = wp_ff;
  assign pc_o = pc_ff;
  // A zero count in the instruction takes the count from the low four bits of the shifted word.
  assign sh_cnt = (cnt_ff == 4'h0) ? opnd_ff[3:0] : cnt_ff;

  csje_shifter #(
    .W(W)
  ) u_shift (
    .val_i(opnd_ff),
    .cnt_i(sh_cnt),
    .op_i(op_ff),
    .res_o(sh_res),
    .carry_o(sh_c)
  );

  function [W-1:0] waddr;
    input [W-1:0] base;
    input [3:0] idx;
    begin
      waddr = base + {{(W-5){1'b0}}, idx, 1'b0};
    end
  endfunction

  // Flag bit n counts from the most significant end of the word.
  function fl;
    input [W-1:0] f;
    input integer n;
    begin
      fl = f[W-1-n];
    end
  endfunction

  // --------------------------------------------------------------------
  // Branch condition
  // --------------------------------------------------------------------
  always @* begin
    take = 1'b0;
    case (cond_ff)
      `CSJE_BR_ALWAYS: take = 1'b1;
      `CSJE_BR_EQUAL: take = fl(flag_ff, 2);
      `CSJE_BR_GREATER: take = fl(flag_ff, 1);
      `CSJE_BR_ABOVE: take = fl(flag_ff, 0) & ~fl(flag_ff, 2);
      `CSJE_BR_ABOVE_EQ: take = fl(flag_ff, 0) | fl(flag_ff, 2);
      `CSJE_BR_BELOW: take = ~fl(flag_ff, 0) & ~fl(flag_ff, 2);
      `CSJE_BR_BELOW_EQ: take = ~fl(flag_ff, 0) | fl(flag_ff, 2);
      `CSJE_BR_LESS: take = ~fl(flag_ff, 1) & ~fl(flag_ff, 2);
      `CSJE_BR_NO_CARRY: take = ~fl(flag_ff, 3);
      `CSJE_BR_NOT_EQUAL: take = ~fl(flag_ff, 2);
      `CSJE_BR_NO_OVFL: take = ~fl(flag_ff, 4);
      `CSJE_BR_ON_CARRY: take = fl(flag_ff, 3);
      `CSJE_BR_ODD_PAR: take = fl(flag_ff, 5);
      default: take = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always @* begin
    nxt_st = st_ff;
    nxt_flag = flag_ff;
    nxt_wp = wp_ff;
    nxt_pc = pc_ff;
    nxt_ctx_wp = ctx_wp_ff;
    nxt_step = step_ff;
    nxt_opnd = opnd_ff;
    nxt_rd = 1'b0;
    nxt_wr = 1'b0;
    nxt_addr = mem_addr_o;
    nxt_wdata = mem_wdata_o;
    nxt_done = 1'b0;
    nxt_xf = 1'b0;
    nxt_xaddr = exec_addr_o;
    res = opnd_ff;
    sum = {1'b0, opnd_ff} + {1'b0, imm_ff};
    cmp = opnd_ff - imm_ff;
    case (st_ff)
      S_IDLE: begin
        if (start_i) begin
          nxt_step = 2'h0;
          case (op_i)
            `CSJE_OP_BRANCH: begin
              nxt_st = S_DONE;
            end
            `CSJE_OP_WP_IMM: begin
              nxt_wp = imm_i;
              nxt_st = S_DONE;
            end
            `CSJE_OP_LMASK_IMM: begin
              nxt_flag = {flag_ff[W-1:4], imm_i[`CSJE_MASK_HI:`CSJE_MASK_LO]};
              nxt_st = S_DONE;
            end
            `CSJE_OP_STORE_FLAG: begin
              nxt_opnd = flag_ff;
              nxt_st = S_WR;
            end
            `CSJE_OP_STORE_WP: begin
              nxt_opnd = wp_ff;
              nxt_st = S_WR;
            end
            `CSJE_OP_LOAD_IMM: begin
              nxt_opnd = imm_i;
              nxt_st = S_WR;
            end
            `CSJE_OP_CTX_CALL: begin
              nxt_rd = 1'b1;
              nxt_addr = disp_i;
              nxt_st = S_WAIT;
            end
            `CSJE_OP_RETURN: begin
              nxt_rd = 1'b1;
              nxt_addr = waddr(wp_ff, `CSJE_WR_OLD_FLAG);
              nxt_st = S_WAIT;
            end
            `CSJE_OP_EXECUTE: begin
              nxt_xf = 1'b1;
              nxt_xaddr = disp_i;
              nxt_st = S_DONE;
            end
            default: begin
              nxt_rd = 1'b1;
              nxt_addr = waddr(wp_ff, reg_i);
              nxt_st = S_WAIT;
            end
          endcase
        end
      end
      S_WAIT: begin
        nxt_opnd = mem_rdata_i;
        nxt_st = S_RD;
      end
      S_RD: begin
        nxt_st = S_WR;
        case (op_ff)
          `CSJE_OP_ADD_IMM: begin
            res = sum[W-1:0];
            nxt_flag[`CSJE_FL_C] = sum[W];
            nxt_flag[`CSJE_FL_OV] = (opnd_ff[W-1] == imm_ff[W-1]) &
              (sum[W-1] != opnd_ff[W-1]);
          end
          `CSJE_OP_AND_IMM: res = opnd_ff & imm_ff;
          `CSJE_OP_OR_IMM: res = opnd_ff | imm_ff;
          `CSJE_OP_CMP_IMM: begin
            nxt_flag[`CSJE_FL_LGT] = opnd_ff > imm_ff;
            nxt_flag[`CSJE_FL_AGT] = $signed(opnd_ff) > $signed(imm_ff);
            nxt_flag[`CSJE_FL_EQ] = cmp == {W{1'b0}};
            nxt_st = S_DONE;
          end
          `CSJE_OP_LOAD_FLAG: begin
            nxt_flag = opnd_ff;
            nxt_st = S_DONE;
          end
          `CSJE_OP_LOAD_WP: begin
            nxt_wp = opnd_ff;
            nxt_st = S_DONE;
          end
          `CSJE_OP_RETURN: begin
            nxt_st = S_SEQ;
          end
          `CSJE_OP_CTX_CALL: begin
            nxt_st = S_SEQ;
          end
          default: begin
            res = sh_res;
            nxt_flag[`CSJE_FL_C] = sh_c;
          end
        endcase
        if (nxt_st == S_WR) begin
          nxt_flag[`CSJE_FL_LGT] = res != {W{1'b0}};
          nxt_flag[`CSJE_FL_AGT] = ~res[W-1] & (res != {W{1'b0}});
          nxt_flag[`CSJE_FL_EQ] = res == {W{1'b0}};
          nxt_opnd = res;
        end
      end
      S_WR: begin
        nxt_wr = 1'b1;
        nxt_addr = waddr(wp_ff, reg_ff);
        nxt_wdata = opnd_ff;
        nxt_st = S_DONE;
      end
      S_SEQ: begin
        nxt_step = step_ff + 2'h1;
        if (op_ff == `CSJE_OP_RETURN) begin
          // restore in order 15, 14, 13
          case (step_ff)
            2'h0: begin
              nxt_flag = opnd_ff;
              nxt_rd = 1'b1;
              nxt_addr = waddr(wp_ff, `CSJE_WR_OLD_PC);
              nxt_st = S_WAIT;
            end
            2'h1: begin
              nxt_pc = opnd_ff;
              nxt_rd = 1'b1;
              nxt_addr = waddr(wp_ff, `CSJE_WR_OLD_WP);
              nxt_st = S_WAIT;
            end
            default: begin
              nxt_wp = opnd_ff;
              nxt_st = S_DONE;
            end
          endcase
        end else begin
          // save old context into new 13-15
          case (step_ff)
            2'h0: begin
              nxt_ctx_wp = opnd_ff;
              nxt_wr = 1'b1;
              nxt_addr = waddr(opnd_ff, `CSJE_WR_OLD_WP);
              nxt_wdata = wp_ff;
            end
            2'h1: begin
              nxt_wr = 1'b1;
              nxt_addr = waddr(ctx_wp_ff, `CSJE_WR_OLD_PC);
              nxt_wdata = pc_ff;
            end
            default: begin
              nxt_wr = 1'b1;
              nxt_addr = waddr(ctx_wp_ff, `CSJE_WR_OLD_FLAG);
              nxt_wdata = flag_ff;
              nxt_wp = ctx_wp_ff;
              nxt_st = S_DONE;
            end
          endcase
        end
      end
      S_DONE: begin
        nxt_done = 1'b1;
        if (op_ff == `CSJE_OP_BRANCH && take) begin
          nxt_pc = pc_ff + disp_i;
        end
        nxt_st = S_IDLE;
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  // --------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------
  // Freezing on ce_i keeps the memory strobes aligned with the fetcher.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= S_IDLE;
      flag_ff <= `CSJE_RST_FLAG;
      wp_ff <= `CSJE_RST_WP;
      pc_ff <= `CSJE_RST_PC;
      op_ff <= 5'h00;
      cond_ff <= 4'h0;
      reg_ff <= 4'h0;
      cnt_ff <= 4'h0;
      imm_ff <= {W{1'b0}};
      ctx_wp_ff <= {W{1'b0}};
      step_ff <= 2'h0;
      opnd_ff <= {W{1'b0}};
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_addr_o <= {W{1'b0}};
      mem_wdata_o <= {W{1'b0}};
      done_o <= 1'b0;
      exec_fetch_o <= 1'b0;
      exec_addr_o <= {W{1'b0}};
    end else if (ce_i) begin
      st_ff <= nxt_st;
      flag_ff <= nxt_flag;
      wp_ff <= nxt_wp;
      pc_ff <= nxt_pc;
      ctx_wp_ff <= nxt_ctx_wp;
      step_ff <= nxt_step;
      opnd_ff <= nxt_opnd;
      mem_rd_o <= nxt_rd;
      mem_wr_o <= nxt_wr;
      mem_addr_o <= nxt_addr;
      mem_wdata_o <= nxt_wdata;
      done_o <= nxt_done;
      exec_fetch_o <= nxt_xf;
      exec_addr_o <= nxt_xaddr;
      if (st_ff[0] && start_i) begin
        op_ff <= op_i;
        cond_ff <= cond_i;
        reg_ff <= reg_i;
        cnt_ff <= cnt_i;
        imm_ff <= imm_i;
      end
    end
  end

endmodule // csje_exec

// *** verilog/csje_map.vh ***
// Constants for the shift, jump and immediate execution unit.
// Assumes a 16-bit word machine with flag bit 0 as the leftmost flag.
`ifndef CSJE_MAP_VH
`define CSJE_MAP_VH

// ----------------------------------------------------------------------
// Operation codes on the op_i port
// ----------------------------------------------------------------------
`define CSJE_OP_SHL_ARITH 5'h00
`define CSJE_OP_SHR_ARITH 5'h01
`define CSJE_OP_ROT_RIGHT 5'h02
`define CSJE_OP_SHR_LOGIC 5'h03
`define CSJE_OP_BRANCH 5'h04
`define CSJE_OP_ADD_IMM 5'h05
`define CSJE_OP_AND_IMM 5'h06
`define CSJE_OP_CMP_IMM 5'h07
`define CSJE_OP_LOAD_IMM 5'h08
`define CSJE_OP_OR_IMM 5'h09
`define CSJE_OP_WP_IMM 5'h0a
`define CSJE_OP_LMASK_IMM 5'h0b
`define CSJE_OP_STORE_FLAG 5'h0c
`define CSJE_OP_LOAD_FLAG 5'h0d
`define CSJE_OP_STORE_WP 5'h0e
`define CSJE_OP_LOAD_WP 5'h0f
`define CSJE_OP_RETURN 5'h10
`define CSJE_OP_CTX_CALL 5'h11
`define CSJE_OP_EXECUTE 5'h12

// ----------------------------------------------------------------------
// Branch condition codes on the cond_i port
// ----------------------------------------------------------------------
`define CSJE_BR_ALWAYS 4'h0
`define CSJE_BR_EQUAL 4'h1
`define CSJE_BR_GREATER 4'h2
`define CSJE_BR_ABOVE 4'h3
`define CSJE_BR_ABOVE_EQ 4'h4
`define CSJE_BR_BELOW 4'h5
`define CSJE_BR_BELOW_EQ 4'h6
`define CSJE_BR_LESS 4'h7
`define CSJE_BR_NO_CARRY 4'h8
`define CSJE_BR_NOT_EQUAL 4'h9
`define CSJE_BR_NO_OVFL 4'h0a
`define CSJE_BR_ON_CARRY 4'h0b
`define CSJE_BR_ODD_PAR 4'h0c

// ----------------------------------------------------------------------
// Flag word bit positions (bit 15 is the most significant bit)
// ----------------------------------------------------------------------
`define CSJE_FL_LGT 15
`define CSJE_FL_AGT 14
`define CSJE_FL_EQ 13
`define CSJE_FL_C 12
`define CSJE_FL_OV 11
`define CSJE_FL_OP 10
`define CSJE_MASK_HI 3
`define CSJE_MASK_LO 0

// ----------------------------------------------------------------------
// Workspace register numbers and reset values
// ----------------------------------------------------------------------
`define CSJE_WR_OLD_WP 4'hd
`define CSJE_WR_OLD_PC 4'he
`define CSJE_WR_OLD_FLAG 4'hf
`define CSJE_RST_FLAG 16'h0000
`define CSJE_RST_WP 16'h0000
`define CSJE_RST_PC 16'h0000

`endif

// *** verilog/csje_shifter.v ***
// Barrel shifter for the four shift operations on a workspace word.
// Assumes the count is already resolved, zero meaning no movement.
`timescale 1ns/1ps
`include "csje_map.vh"

module csje_shifter #(
  parameter W = 16
) (
  input wire [W-1:0] val_i,
  input wire [3:0] cnt_i,
  input wire [4:0] op_i,
  output reg [W-1:0] res_o,
  output reg carry_o
);

  reg [W-1:0] v;
  reg c;
  integer k;

  always @* begin
    v = val_i;
    c = 1'b0;
    for (k = 0; k < W; k = k + 1) begin
      if (k < cnt_i) begin
        case (op_i)
          `CSJE_OP_SHL_ARITH: begin
            c = v[W-1];
            v = {v[W-2:0], 1'b0};
          end
          `CSJE_OP_SHR_ARITH: begin
            c = v[0];
            v = {v[W-1], v[W-1:1]};
          end
          `CSJE_OP_ROT_RIGHT: begin
            c = v[0];
            v = {v[0], v[W-1:1]};
          end
          default: begin
            c = v[0];
            v = {1'b0, v[W-1:1]};
          end
        endcase
      end
    end
    res_o = v;
    carry_o = c;
  end

endmodule // csje_shifter

// *** tb/csje_mem_model.sv ***
// Workspace memory model on the far side of the execution unit.
// Assumes word addresses below 16'h0200 and read data within the strobe.
`timescale 1ns/1ps
module csje_mem_model (
  input wire clk_i,
  input wire rd_i,
  input wire wr_i,
  input wire [15:0] addr_i,
  input wire [15:0] wdata_i,
  output wire [15:0] rdata_o
);
  reg [15:0] mem [0:255];
  // The unit latches read data at the edge that ends its strobe, so the
  // word follows the address at once; outside a read it is scrambled.
  assign rdata_o = rd_i ? mem[addr_i[8:1]] : ~mem[addr_i[8:1]];
  always @(posedge clk_i) begin
    if (wr_i)
      mem[addr_i[8:1]] <= wdata_i;
  end
endmodule // csje_mem_model

// *** tb/csje_exec_properties.sv ***
// Timing and state checks on the ports of the execution unit.
// Assumes binding to csje_exec with its own clock and reset.
`timescale 1ns/1ps
`include "csje_map.vh"
module csje_exec_props #(
  parameter W = 16
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire start_i,
  input wire [4:0] op_i,
  input wire [3:0] reg_i,
  input wire [W-1:0] imm_i,
  input wire busy_o,
  input wire done_o,
  input wire mem_rd_o,
  input wire mem_wr_o,
  input wire [W-1:0] mem_addr_o,
  input wire [W-1:0] mem_wdata_o,
  input wire exec_fetch_o,
  input wire [W-1:0] flag_word_o,
  input wire [W-1:0] wp_o
);
  // ------------------------------------------------------------------
  // Request capture
  // ------------------------------------------------------------------
  reg [4:0] op_q;
  reg [3:0] reg_q;
  reg [W-1:0] imm_q, flag_q, wp_q;
  wire acc = start_i && ce_i && !busy_o;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_q <= 5'h1f;
      reg_q <= 4'h0;
      imm_q <= {W{1'b0}};
      flag_q <= {W{1'b0}};
      wp_q <= {W{1'b0}};
    end else if (acc) begin
      op_q <= op_i;
      reg_q <= reg_i;
      imm_q <= imm_i;
      flag_q <= flag_word_o;
      wp_q <= wp_o;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  busy_on_take_a: assert property (acc |=> busy_o)
    else $error("busy missing after start");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  read_addr_a: assert property (acc && op_i == `CSJE_OP_ADD_IMM |=>
    mem_rd_o && mem_addr_o == wp_q + {{(W-5){1'b0}}, reg_q, 1'b0})
    else $error("bad register read address");
  cmp_no_write_a: assert property (acc && op_i == `CSJE_OP_CMP_IMM |=>
    !mem_wr_o [*4]) else $error("compare wrote the register");
  branch_time_a: assert property (acc && op_i == `CSJE_OP_BRANCH |->
    ##2 done_o) else $error("branch latency wrong");
  ptr_load_a: assert property (done_o && op_q == `CSJE_OP_WP_IMM |->
    wp_o == imm_q && flag_word_o == flag_q)
    else $error("pointer load wrong");
  mask_load_a: assert property (done_o && op_q == `CSJE_OP_LMASK_IMM |->
    flag_word_o == {flag_q[W-1:4], imm_q[3:0]})
    else $error("mask load wrong");
  exec_fetch_a: assert property (acc && op_i == `CSJE_OP_EXECUTE |->
    ##[1:2] exec_fetch_o) else $error("execute fetch missing");
  store_wp_a: assert property (mem_wr_o && op_q == `CSJE_OP_STORE_WP |->
    mem_wdata_o == wp_o) else $error("pointer store data wrong");
  cover property (done_o && op_q == `CSJE_OP_RETURN);
  cover property (acc && op_i == `CSJE_OP_CTX_CALL);
  cover property (exec_fetch_o);
endmodule // csje_exec_props

// *** tb/csje_exec_test.sv ***
// Self-checking bench for the execution unit and workspace memory.
// Assumes csje_map.vh is on the include path.
`timescale 1ns/1ps
`include "csje_map.vh"
module csje_exec_test;
  reg clk_i, rst_n_i, start_i, ce_i;
  reg [4:0] op_i;
  reg [3:0] cond_i, reg_i, cnt_i;
  reg [15:0] imm_i, disp_i, e_pc, e_wp, e;
  wire busy_o, done_o, mem_rd_o, mem_wr_o, exec_fetch_o;
  wire [15:0] mem_addr_o, mem_wdata_o, rdata, exec_addr_o;
  wire [15:0] flag_word_o, wp_o, pc_o;
  integer num_errors, check_count, i, c, k;
  reg [5:0] f;
  csje_exec #(.W(16)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .start_i(start_i), .op_i(op_i), .cond_i(cond_i), .reg_i(reg_i),
    .cnt_i(cnt_i), .imm_i(imm_i), .disp_i(disp_i), .mem_rdata_i(rdata),
    .busy_o(busy_o), .done_o(done_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .exec_fetch_o(exec_fetch_o),
    .exec_addr_o(exec_addr_o), .flag_word_o(flag_word_o), .wp_o(wp_o),
    .pc_o(pc_o));
  csje_mem_model u_mem (.clk_i(clk_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(rdata));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function integer wi(input [3:0] r);
    wi = e_wp[8:1] + r;
  endfunction
  function br(input [3:0] cc, input [5:0] s);
    case (cc)
      4'h0: br = 1'b1;
      4'h1: br = s[2];
      4'h2: br = s[1];
      4'h3: br = s[0] & ~s[2];
      4'h4: br = s[0] | s[2];
      4'h5: br = ~s[0] & ~s[2];
      4'h6: br = ~s[0] | s[2];
      4'h7: br = ~s[1] & ~s[2];
      4'h8: br = ~s[3];
      4'h9: br = ~s[2];
      4'ha: br = ~s[4];
      4'hb: br = s[3];
      default: br = s[5];
    endcase
  endfunction
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        num_errors = num_errors + 1;
      end
    end
  endtask
  task run(input [4:0] o, input [3:0] cc, r, n, input [15:0] im, d);
    begin
      @(posedge clk_i);
      op_i <= o;
      cond_i <= cc;
      reg_i <= r;
      cnt_i <= n;
      imm_i <= im;
      disp_i <= d;
      start_i <= 1'b1;
      @(posedge clk_i);
      start_i <= 1'b0;
      k = 0;
      @(negedge clk_i);
      while (done_o !== 1'b1 && k < 50) begin
        @(negedge clk_i);
        k = k + 1;
      end
      if (k >= 50)
        chk(16'hdead, 16'h0000);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task t_regs;
    begin
      chk(flag_word_o, 16'h0000);
      chk(pc_o, 16'h0000);
      run(`CSJE_OP_WP_IMM, 0, 0, 0, 16'h0040, 0);
      chk(wp_o, 16'h0040);
      e_wp = 16'h0040;
      u_mem.mem[wi(4)] = 16'ha5a0;
      run(`CSJE_OP_LOAD_FLAG, 0, 4, 0, 0, 0);
      chk(flag_word_o, 16'ha5a0);
      run(`CSJE_OP_LMASK_IMM, 0, 0, 0, 16'hfffc, 0);
      chk(flag_word_o, 16'ha5ac);
      run(`CSJE_OP_STORE_FLAG, 0, 5, 0, 0, 0);
      chk(u_mem.mem[wi(5)], 16'ha5ac);
      run(`CSJE_OP_STORE_WP, 0, 6, 0, 0, 0);
      chk(u_mem.mem[wi(6)], 16'h0040);
      u_mem.mem[wi(7)] = 16'h0060;
      run(`CSJE_OP_LOAD_WP, 0, 7, 0, 0, 0);
      chk(wp_o, 16'h0060);
      run(`CSJE_OP_WP_IMM, 0, 0, 0, 16'h0040, 0);
      chk(flag_word_o, 16'ha5ac);
      $display("register move test done");
    end
  endtask
  task t_freeze;
    begin
      @(posedge clk_i);
      ce_i <= 1'b0;
      op_i <= `CSJE_OP_WP_IMM;
      imm_i <= 16'h0050;
      start_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      ce_i <= 1'b1;
      start_i <= 1'b0;
      @(negedge clk_i);
      chk(wp_o, 16'h0040);
      chk({15'h0000, busy_o}, 16'h0000);
      $display("clock enable test done");
    end
  endtask
  task t_alu;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        u_mem.mem[wi(1)] = 16'h8421;
        run(i[4:0], 0, 1, 3, 0, 0);
        e = (i == 0) ? 16'h2108 : (i == 1) ? 16'hf084 :
          (i == 2) ? 16'h3084 : 16'h1084;
        chk(u_mem.mem[wi(1)], e);
      end
      u_mem.mem[wi(1)] = 16'h8421;
      run(`CSJE_OP_SHR_LOGIC, 0, 1, 0, 0, 0);
      chk(u_mem.mem[wi(1)], 16'h4210);
      for (i = 0; i < 4; i = i + 1) begin
        u_mem.mem[wi(2)] = 16'h1234;
        run((i == 0) ? `CSJE_OP_ADD_IMM : (i == 1) ? `CSJE_OP_AND_IMM :
          (i == 2) ? `CSJE_OP_OR_IMM : `CSJE_OP_LOAD_IMM,
          0, 2, 0, 16'h0f0f, 0);
        e = (i == 0) ? 16'h2143 : (i == 1) ? 16'h0204 :
          (i == 2) ? 16'h1f3f : 16'h0f0f;
        chk(u_mem.mem[wi(2)], e);
      end
      u_mem.mem[wi(2)] = 16'h1234;
      run(`CSJE_OP_CMP_IMM, 0, 2, 0, 16'h1234, 0);
      chk(u_mem.mem[wi(2)], 16'h1234);
      chk({15'h0000, flag_word_o[13]}, 16'h0001);
      $display("shift and immediate test done");
    end
  endtask
  task t_branch;
    begin
      for (i = 0; i < 64; i = i + 1) begin
        f = i[5:0];
        u_mem.mem[wi(8)] = {f[0], f[1], f[2], f[3], f[4], f[5], 10'h000};
        run(`CSJE_OP_LOAD_FLAG, 0, 8, 0, 0, 0);
        for (c = 0; c < 13; c = c + 1) begin
          run(`CSJE_OP_BRANCH, c[3:0], 0, 0, 0, 16'h0010);
          if (br(c[3:0], f))
            e_pc = e_pc + 16'h0010;
          chk(pc_o, e_pc);
        end
      end
      $display("branch test done");
    end
  endtask
  task t_ctx;
    begin
      u_mem.mem[80] = 16'h0080;
      run(`CSJE_OP_CTX_CALL, 0, 0, 0, 0, 16'h00a0);
      chk(wp_o, 16'h0080);
      chk(u_mem.mem[77], 16'h0040);
      chk(u_mem.mem[78], e_pc);
      chk(u_mem.mem[79], 16'hfc00);
      u_mem.mem[77] = 16'h0030;
      u_mem.mem[78] = 16'h1230;
      u_mem.mem[79] = 16'h4c00;
      run(`CSJE_OP_RETURN, 0, 0, 0, 0, 0);
      chk(wp_o, 16'h0030);
      chk(pc_o, 16'h1230);
      chk(flag_word_o, 16'h4c00);
      run(`CSJE_OP_EXECUTE, 0, 0, 0, 0, 16'h0100);
      chk(exec_addr_o, 16'h0100);
      chk(pc_o, 16'h1230);
      $display("context test done");
    end
  endtask
  // ------------------------------------------------------------------
  // Clock, sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    num_errors = 0;
    check_count = 0;
    rst_n_i = 1'b0;
    start_i = 1'b0;
    ce_i = 1'b1;
    op_i = 5'h00;
    cond_i = 4'h0;
    reg_i = 4'h0;
    cnt_i = 4'h0;
    imm_i = 16'h0000;
    disp_i = 16'h0000;
    e_pc = 16'h0000;
    e_wp = 16'h0000;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_freeze;
    t_alu;
    t_branch;
    t_ctx;
    finish_test;
  end
  // The run needs about 3000 cycles; the limit allows about five times that.
  initial begin
    #400000;
    num_errors = num_errors + 1;
    $display("watchdog expired");
    finish_test;
  end
endmodule // csje_exec_test
bind csje_exec csje_exec_props #(.W(W)) u_props (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .ce_i(ce_i), .start_i(start_i), .op_i(op_i),
  .reg_i(reg_i), .imm_i(imm_i), .busy_o(busy_o), .done_o(done_o),
  .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o), .exec_fetch_o(exec_fetch_o),
  .flag_word_o(flag_word_o), .wp_o(wp_o));
